// ### rtl/sric_config.sv
// spread rate and interrupt pin configuration registers with mode decode
//
// Summary of operation
// R01: rate bit 2 picks 32 or 64 chips
// R02: rate bit 1 picks double or normal rate
// R03: double rate honoured only with 32-chip codes
// R04: double rate splits 64-chip code, two bits each
// R05: bit rate 62.5k double, 32k normal 32-chip
// R06: normal 32-chip mode correlates two distinct codes
// R07: rate bit 0 picks 12x or 6x sampling
// R08: 12x only with 32-chip normal rate
// R09: host never writes patterns 001,010,011,111
// R10: host sets dependent bits with 32-chip choice
// R11: host writes zeros to unused upper bits
// R12: pin modes 11 open source, 10 open drain
// R13: pin modes 01 push-pull, 00 inverted push-pull
// R14: half select picks upper or lower 32 chips
// R15: interrupt pin is data plus output enable
// R16: reset gives rate 0, pin config 1
`timescale 1ns/1ps
`include "sric_defs.svh"
module sric_config import sric_pkg::*; #(
  parameter int N64_BPS = `SRIC_N64_BPS,
  parameter int N32_BPS = `SRIC_N32_BPS,
  parameter int DDR_BPS = `SRIC_DDR_BPS
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [`SRIC_ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [`SRIC_DATA_W-1:0] reg_wdata_in,
  input wire logic code_half_sel_in,
  input wire logic [`SRIC_CODE_W-1:0] pn_code_in,
  input wire logic irq_in,
  input wire logic corr_valid_in,
  input wire logic corr_half_in,
  input wire logic corr_pol_in,
  output logic [`SRIC_DATA_W-1:0] reg_rdata_out,
  output logic cfg_reject_out,
  output logic code_len_32_out,
  output logic double_rate_out,
  output logic oversample_12x_out,
  output logic [`SRIC_HALF_W-1:0] corr_code_a_out,
  output logic [`SRIC_HALF_W-1:0] corr_code_b_out,
  output logic corr_dual_out,
  output logic bit_tick_out,
  output logic [1:0] rx_bits_out,
  output logic rx_bits_valid_out,
  output logic rx_two_bits_out,
  output logic irq_pin_out,
  output logic irq_pin_oe_out
);
  localparam int DDR_CYC_I = `SRIC_CLK_HZ / DDR_BPS;
  localparam int N32_CYC_I = `SRIC_CLK_HZ / N32_BPS;
  localparam int N64_CYC_I = `SRIC_CLK_HZ / N64_BPS;
  localparam logic [`SRIC_TICK_W-1:0] DDR_CYC = DDR_CYC_I[`SRIC_TICK_W-1:0];
  localparam logic [`SRIC_TICK_W-1:0] N32_CYC = N32_CYC_I[`SRIC_TICK_W-1:0];
  localparam logic [`SRIC_TICK_W-1:0] N64_CYC = N64_CYC_I[`SRIC_TICK_W-1:0];

  logic [`SRIC_RATE_HI:0] rate_cfg, next_rate_cfg;
  logic [`SRIC_IRQ_HI:0] irq_cfg, next_irq_cfg;
  logic [`SRIC_DATA_W-1:0] next_rdata;
  logic next_reject;
  logic rate_bad;

  // pattern check on the written rate bits
  always_comb begin
    unique case (reg_wdata_in[`SRIC_RATE_HI:0])
      `SRIC_BAD_001, `SRIC_BAD_010, `SRIC_BAD_011, `SRIC_BAD_111: rate_bad = 1'b1; // see R09
      default: rate_bad = 1'b0;
    endcase
  end

  always_comb begin
    next_rate_cfg = rate_cfg;
    next_irq_cfg = irq_cfg;
    next_rdata = reg_rdata_out;
    next_reject = 1'b0;
    if (reg_wr_in && reg_addr_in == `SRIC_OFS_RATE) begin
      if (rate_bad) begin
        next_reject = 1'b1;
      end else begin
        next_rate_cfg = reg_wdata_in[`SRIC_RATE_HI:0]; // see R01
      end
    end
    if (reg_wr_in && reg_addr_in == `SRIC_OFS_IRQ) begin
      next_irq_cfg = reg_wdata_in[`SRIC_IRQ_HI:0]; // see R12
    end
    if (reg_rd_in) begin
      // unused upper bits are not stored and read back as zero
      unique case (reg_addr_in)
        `SRIC_OFS_RATE: next_rdata = {{(`SRIC_DATA_W-`SRIC_RATE_HI-1){1'b0}}, rate_cfg}; // see R11
        `SRIC_OFS_IRQ: next_rdata = {{(`SRIC_DATA_W-`SRIC_IRQ_HI-1){1'b0}}, irq_cfg};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rate_cfg <= `SRIC_RATE_RST; // see R16
      irq_cfg <= `SRIC_IRQ_RST; // see R16
      reg_rdata_out <= '0;
      cfg_reject_out <= 1'b0;
    end else begin
      rate_cfg <= next_rate_cfg;
      irq_cfg <= next_irq_cfg;
      reg_rdata_out <= next_rdata;
      cfg_reject_out <= next_reject;
    end
  end

  // mode decode and correlator code selection
  sric_mode_e mode;
  logic next_len32, next_ddr, next_os12, next_dual;
  logic [`SRIC_HALF_W-1:0] next_code_a, next_code_b;
  logic [`SRIC_HALF_W-1:0] code_lo, code_hi;

  assign code_lo = pn_code_in[`SRIC_HALF_W-1:0];
  assign code_hi = pn_code_in[`SRIC_CODE_W-1:`SRIC_HALF_W];

  always_comb begin
    if (!rate_cfg[`SRIC_BIT_CODE32]) begin
      mode = SRIC_N64; // see R01
    end else if (rate_cfg[`SRIC_BIT_DDR]) begin
      mode = SRIC_DDR; // see R02 see R03
    end else begin
      mode = SRIC_N32;
    end
  end

  always_comb begin
    next_len32 = 1'b0;
    next_ddr = 1'b0;
    next_os12 = 1'b0;
    next_dual = 1'b0;
    next_code_a = code_lo;
    next_code_b = code_hi;
    unique case (mode)
      SRIC_N64: begin
        next_code_a = code_lo;
        next_code_b = code_hi;
      end
      SRIC_N32: begin
        next_len32 = 1'b1;
        next_os12 = rate_cfg[`SRIC_BIT_OS12]; // see R07 see R08
        next_dual = 1'b1; // see R06
        next_code_a = code_half_sel_in ? code_hi : code_lo; // see R14
        next_code_b = code_half_sel_in ? code_lo : code_hi; // see R06
      end
      SRIC_DDR: begin
        next_len32 = 1'b1;
        next_ddr = 1'b1;
        next_code_a = code_lo; // see R04
        next_code_b = code_hi; // see R04
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      code_len_32_out <= 1'b0;
      double_rate_out <= 1'b0;
      oversample_12x_out <= 1'b0;
      corr_dual_out <= 1'b0;
      corr_code_a_out <= '0;
      corr_code_b_out <= '0;
    end else begin
      code_len_32_out <= next_len32;
      double_rate_out <= next_ddr;
      oversample_12x_out <= next_os12;
      corr_dual_out <= next_dual;
      corr_code_a_out <= next_code_a;
      corr_code_b_out <= next_code_b;
    end
  end

  // raw bit rate enable
  logic [`SRIC_TICK_W-1:0] tick_cnt, next_tick_cnt, tick_period;
  logic next_tick;

  always_comb begin
    tick_period = N64_CYC;
    unique case (mode)
      SRIC_DDR: tick_period = DDR_CYC; // see R05
      SRIC_N32: tick_period = N32_CYC; // see R05
      SRIC_N64: tick_period = N64_CYC;
    endcase
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 1'b1;
    if (tick_cnt >= tick_period - 1'b1) begin
      next_tick_cnt = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt <= '0;
      bit_tick_out <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      bit_tick_out <= next_tick;
    end
  end

  // received code decode: double rate yields two bits per half
  logic [1:0] next_rx_bits;
  logic next_rx_valid, next_rx_two;

  always_comb begin
    next_rx_bits = rx_bits_out;
    next_rx_valid = corr_valid_in;
    next_rx_two = rx_two_bits_out;
    if (corr_valid_in) begin
      if (mode == SRIC_DDR) begin
        next_rx_bits = {corr_half_in, corr_pol_in}; // see R04
        next_rx_two = 1'b1;
      end else begin
        next_rx_bits = {1'b0, corr_pol_in};
        next_rx_two = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_bits_out <= '0;
      rx_bits_valid_out <= 1'b0;
      rx_two_bits_out <= 1'b0;
    end else begin
      rx_bits_out <= next_rx_bits;
      rx_bits_valid_out <= next_rx_valid;
      rx_two_bits_out <= next_rx_two;
    end
  end

  // interrupt pin drive as level plus enable
  logic next_pin, next_pin_oe;

  always_comb begin
    unique case (irq_cfg)
      `SRIC_IRQ_OPEN_SRC: begin
        next_pin = 1'b1; // see R12 see R15
        next_pin_oe = irq_in;
      end
      `SRIC_IRQ_OPEN_DRN: begin
        next_pin = 1'b0; // see R12 see R15
        next_pin_oe = irq_in;
      end
      `SRIC_IRQ_CMOS: begin
        next_pin = irq_in; // see R13
        next_pin_oe = 1'b1;
      end
      `SRIC_IRQ_CMOS_INV: begin
        next_pin = !irq_in; // see R13
        next_pin_oe = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_pin_out <= 1'b0;
      irq_pin_oe_out <= 1'b0;
    end else begin
      irq_pin_out <= next_pin;
      irq_pin_oe_out <= next_pin_oe;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_rate_write;
    reg_wr_in && reg_addr_in == `SRIC_OFS_RATE && !rate_bad;
  endsequence

  property p_code_len;
    s_rate_write |=> ##1 code_len_32_out == $past(reg_wdata_in[`SRIC_BIT_CODE32], 2);
  endproperty
  a_code_len: assert property (p_code_len) else $error("code length not applied"); // see R01

  property p_ddr_only32;
    double_rate_out |-> code_len_32_out && !oversample_12x_out;
  endproperty
  a_ddr_only32: assert property (p_ddr_only32) else $error("double rate without 32 chips"); // see R03

  property p_ddr_set;
    s_rate_write |=> ##1 double_rate_out == ($past(reg_wdata_in[2:1], 2) == 2'b11);
  endproperty
  a_ddr_set: assert property (p_ddr_set) else $error("double rate not applied"); // see R02

  property p_os12;
    s_rate_write |=> ##1 oversample_12x_out == ($past(reg_wdata_in[2:0], 2) == 3'b101);
  endproperty
  a_os12: assert property (p_os12) else $error("oversampling wrong"); // see R07 see R08

  property p_reject;
    reg_wr_in && reg_addr_in == `SRIC_OFS_RATE && rate_bad |=> cfg_reject_out
      && rate_cfg == $past(rate_cfg);
  endproperty
  a_reject: assert property (p_reject) else $error("invalid rate pattern stored"); // see R09

  property p_ddr_halves;
    ##1 double_rate_out && $stable(pn_code_in) && $past(mode == SRIC_DDR) |->
      corr_code_a_out == $past(code_lo) && corr_code_b_out == $past(code_hi);
  endproperty
  a_ddr_halves: assert property (p_ddr_halves) else $error("double rate halves wrong"); // see R04

  property p_half_sel;
    mode == SRIC_N32 && code_half_sel_in |=> corr_code_a_out == $past(code_hi) && corr_dual_out;
  endproperty
  a_half_sel: assert property (p_half_sel) else $error("half select ignored"); // see R14 see R06

  property p_tick_ddr;
    bit_tick_out && mode == SRIC_DDR && $stable(mode) |->
      ##1 !bit_tick_out [*8];
  endproperty
  a_tick_ddr: assert property (p_tick_ddr) else $error("bit tick too fast"); // see R05

  property p_open_drain;
    irq_cfg == `SRIC_IRQ_OPEN_DRN |=> !irq_pin_out && irq_pin_oe_out == $past(irq_in);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drive wrong"); // see R12

  property p_cmos_inv;
    irq_cfg == `SRIC_IRQ_CMOS_INV |=> irq_pin_oe_out && irq_pin_out != $past(irq_in);
  endproperty
  a_cmos_inv: assert property (p_cmos_inv) else $error("inverted drive wrong"); // see R13
endmodule : sric_config

// ### rtl/sric_defs.svh
// constants for the spread rate and interrupt pin configuration block
`ifndef SRIC_DEFS_SVH
`define SRIC_DEFS_SVH
`define SRIC_ADDR_W 6
`define SRIC_DATA_W 8
`define SRIC_OFS_RATE 6'h04
`define SRIC_OFS_IRQ 6'h05
`define SRIC_RATE_RST 3'h0
`define SRIC_IRQ_RST 2'h1
`define SRIC_BIT_CODE32 2
`define SRIC_BIT_DDR 1
`define SRIC_BIT_OS12 0
`define SRIC_RATE_HI 2
`define SRIC_IRQ_HI 1
`define SRIC_BAD_001 3'h1
`define SRIC_BAD_010 3'h2
`define SRIC_BAD_011 3'h3
`define SRIC_BAD_111 3'h7
`define SRIC_IRQ_OPEN_SRC 2'h3
`define SRIC_IRQ_OPEN_DRN 2'h2
`define SRIC_IRQ_CMOS 2'h1
`define SRIC_IRQ_CMOS_INV 2'h0
`define SRIC_HALF_W 32
`define SRIC_CODE_W 64
`define SRIC_CLK_HZ 100000000
`define SRIC_DDR_BPS 62500
`define SRIC_N32_BPS 32000
`define SRIC_N64_BPS 16000
`define SRIC_TICK_W 13
`endif

// ### rtl/sric_pkg.sv
// types for the spread rate and interrupt pin configuration block
package sric_pkg;
  typedef enum logic [1:0] {
    SRIC_N64 = 2'b00,
    SRIC_N32 = 2'b01,
    SRIC_DDR = 2'b10
  } sric_mode_e;
endpackage : sric_pkg

// ### bench/sric_host_model.sv
// host model driving the byte-wide register port
`timescale 1ns/1ps
`include "sric_defs.svh"
module sric_host_model (
  input wire logic sys_clk_in,
  output logic [`SRIC_ADDR_W-1:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [`SRIC_DATA_W-1:0] reg_wdata_out
);
  initial begin
    reg_addr_out = '0;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = '0;
  end
  // callers pass valid bytes, zero-padded except 8'hfc, unless a refusal is wanted
  task automatic wr(input logic [`SRIC_ADDR_W-1:0] a, input logic [`SRIC_DATA_W-1:0] d);
    @(posedge sys_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_out <= 1'b0;
    // released bus shows the inverse, not the old value
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask : wr
  task automatic rd(input logic [`SRIC_ADDR_W-1:0] a);
    @(posedge sys_clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
  endtask : rd
endmodule : sric_host_model

// ### bench/spread_rate_and_irq_config_test.sv
// self-checking bench of the rate and interrupt pin configuration block
`timescale 1ns/1ps
`include "sric_defs.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", n, e, a); end end
module spread_rate_and_irq_config_test;
  typedef struct {
    logic [7:0] rate;
    logic [7:0] irqc;
    logic irq;
    logic [3:0] mode;
    logic pin;
    logic oe;
  } sric_row_s;
  logic sys_clk_in, rst_n_in, reg_wr_in, reg_rd_in, code_half_sel_in, irq_in;
  logic corr_valid_in, corr_half_in, corr_pol_in;
  logic [5:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out;
  logic [63:0] pn_code_in;
  logic cfg_reject_out, code_len_32_out, double_rate_out, oversample_12x_out, corr_dual_out;
  logic bit_tick_out, rx_bits_valid_out, rx_two_bits_out, irq_pin_out, irq_pin_oe_out;
  logic [31:0] corr_code_a_out, corr_code_b_out;
  logic [1:0] rx_bits_out;
  int mismatches = 0;
  int samples_checked = 0;
  sric_row_s rows[8] = '{'{8'h00, 8'h03, 1'b1, 4'h0, 1'b1, 1'b1},
    '{8'h00, 8'h03, 1'b0, 4'h0, 1'b1, 1'b0}, '{8'h04, 8'h02, 1'b1, 4'h9, 1'b0, 1'b1},
    '{8'h04, 8'h02, 1'b0, 4'h9, 1'b0, 1'b0}, '{8'h05, 8'h01, 1'b1, 4'hb, 1'b1, 1'b1},
    '{8'h06, 8'h01, 1'b0, 4'hc, 1'b0, 1'b1}, '{8'h04, 8'h00, 1'b1, 4'h9, 1'b0, 1'b1},
    '{8'h00, 8'h00, 1'b0, 4'h0, 1'b1, 1'b1}};
  logic [7:0] bad[4] = '{8'h01, 8'h02, 8'h03, 8'h07};
  sric_config #(.N64_BPS(2500000), .N32_BPS(5000000), .DDR_BPS(10000000)) dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .code_half_sel_in(code_half_sel_in), .pn_code_in(pn_code_in), .irq_in(irq_in),
    .corr_valid_in(corr_valid_in), .corr_half_in(corr_half_in), .corr_pol_in(corr_pol_in),
    .reg_rdata_out(reg_rdata_out), .cfg_reject_out(cfg_reject_out),
    .code_len_32_out(code_len_32_out), .double_rate_out(double_rate_out),
    .oversample_12x_out(oversample_12x_out), .corr_code_a_out(corr_code_a_out),
    .corr_code_b_out(corr_code_b_out), .corr_dual_out(corr_dual_out),
    .bit_tick_out(bit_tick_out), .rx_bits_out(rx_bits_out),
    .rx_bits_valid_out(rx_bits_valid_out), .rx_two_bits_out(rx_two_bits_out),
    .irq_pin_out(irq_pin_out), .irq_pin_oe_out(irq_pin_oe_out));
  sric_host_model host (.sys_clk_in(sys_clk_in), .reg_addr_out(reg_addr_in),
    .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in), .reg_wdata_out(reg_wdata_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    host.rd(a);
    #1;
    `CHK("rdata", e, reg_rdata_out)
  endtask : rdchk
  task automatic dec(input logic h, input logic p, input logic [1:0] e, input logic two);
    @(posedge sys_clk_in);
    corr_half_in <= h;
    corr_pol_in <= p;
    corr_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    corr_valid_in <= 1'b0;
    #1;
    `CHK("rx", {1'b1, two, e}, {rx_bits_valid_out, rx_two_bits_out, rx_bits_out})
  endtask : dec
  task automatic gap(input int e);
    int n;
    n = 0;
    while (bit_tick_out !== 1'b1 && n < 100) begin
      @(negedge sys_clk_in);
      n++;
    end
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (bit_tick_out !== 1'b1 && n < 100);
    `CHK("tick_gap", e, n)
  endtask : gap
  task summarize;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  initial begin
    #300us;
    mismatches++;
    summarize();
  end
  initial begin
    rst_n_in = 1'b0;
    code_half_sel_in = 1'b1;
    pn_code_in = 64'h0123456789abcdef;
    irq_in = 1'b1;
    corr_valid_in = 1'b0;
    corr_half_in = 1'b0;
    corr_pol_in = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1;
    `CHK("reset_out", 5'h03, {code_len_32_out, double_rate_out, oversample_12x_out,
      irq_pin_out, irq_pin_oe_out})
    rdchk(6'h04, 8'h00);
    rdchk(6'h05, 8'h01);
    foreach (rows[i]) begin
      host.wr(6'h04, rows[i].rate);
      host.wr(6'h05, rows[i].irqc);
      irq_in <= rows[i].irq;
      repeat (3) @(posedge sys_clk_in);
      #1;
      `CHK("mode", rows[i].mode, {code_len_32_out, double_rate_out, oversample_12x_out,
        corr_dual_out})
      `CHK("pin", {rows[i].pin, rows[i].oe}, {irq_pin_out, irq_pin_oe_out})
      rdchk(6'h05, rows[i].irqc);
    end
    host.wr(6'h04, 8'hfc);
    #1;
    `CHK("no_reject", 1'b0, cfg_reject_out)
    rdchk(6'h04, 8'h04);
    rdchk(6'h06, 8'h00);
    repeat (2) @(posedge sys_clk_in);
    #1;
    `CHK("code_hi", {32'h01234567, 32'h89abcdef}, {corr_code_a_out, corr_code_b_out})
    @(posedge sys_clk_in);
    code_half_sel_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1;
    `CHK("code_lo", {32'h89abcdef, 32'h01234567}, {corr_code_a_out, corr_code_b_out})
    dec(1'b1, 1'b1, 2'b01, 1'b0);
    host.wr(6'h04, 8'h06);
    repeat (2) @(posedge sys_clk_in);
    dec(1'b1, 1'b0, 2'b10, 1'b1);
    dec(1'b0, 1'b1, 2'b01, 1'b1);
    foreach (bad[i]) begin
      host.wr(6'h04, bad[i]);
      #1;
      `CHK("reject", 1'b1, cfg_reject_out)
      rdchk(6'h04, 8'h06);
    end
    gap(10);
    host.wr(6'h04, 8'h04);
    gap(20);
    host.wr(6'h04, 8'h00);
    gap(40);
    // mid-run reset from a non-default setting
    host.wr(6'h04, 8'h05);
    host.wr(6'h05, 8'h02);
    irq_in <= 1'b1;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1;
    `CHK("rerun_out", 5'h03, {code_len_32_out, double_rate_out, oversample_12x_out,
      irq_pin_out, irq_pin_oe_out})
    rdchk(6'h04, 8'h00);
    rdchk(6'h05, 8'h01);
    summarize();
  end
endmodule : spread_rate_and_irq_config_test
